// [timer16_pkg.sv]
package timer16_pkg;

    // Byte addresses of the registers on the bus, one aligned word each.
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
    localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
    localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
    localparam logic [7:0] ADDR_CMP1_LO = 8'h18;
    localparam logic [7:0] ADDR_CMP2_HI = 8'h1c;
    localparam logic [7:0] ADDR_CMP2_LO = 8'h20;
    localparam logic [7:0] ADDR_CNT_HI = 8'h24;
    localparam logic [7:0] ADDR_CNT_LO = 8'h28;
    localparam logic [7:0] ADDR_ALT_HI = 8'h2c;
    localparam logic [7:0] ADDR_ALT_LO = 8'h30;
    localparam logic [7:0] ADDR_CAP2_HI = 8'h34;
    localparam logic [7:0] ADDR_CAP2_LO = 8'h38;

    // Reset and reload values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'hfffc;
    localparam logic [15:0] COUNTER_TOP = 16'hffff;
    localparam logic [15:0] PULSE_CAPTURE = 16'hfffd;
    localparam logic [15:0] COMPARE_RESET = 16'h8000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;

    // Clock source encodings and prescaler masks (divide minus one).
    localparam logic [1:0] CLK_DIV4 = 2'b00;
    localparam logic [1:0] CLK_DIV2 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT = 2'b11;
    localparam logic [2:0] MASK_DIV4 = 3'h3;
    localparam logic [2:0] MASK_DIV2 = 3'h1;
    localparam logic [2:0] MASK_DIV8 = 3'h7;

    // Control register one fields, bit 7 down to bit 0.
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_level_two;
        logic force_level_one;
        logic level_bit_two;
        logic capture_edge_one;
        logic level_bit_one;
    } ctrl_one_t;

    // Control register two fields, bit 7 down to bit 0.
    typedef struct packed {
        logic compare_pin_one_en;
        logic compare_pin_two_en;
        logic single_pulse_sel;
        logic pwm_sel;
        logic [1:0] clock_source_sel;
        logic capture_edge_two;
        logic ext_count_edge;
    } ctrl_two_t;

    // Hardware flags, in their status bit order 7 down to 3.
    typedef struct packed {
        logic capture_flag_one;
        logic match_flag_one;
        logic wrap_flag;
        logic capture_flag_two;
        logic match_flag_two;
    } flags_t;

    // One compare output pin: level and enable.
    typedef struct packed {
        logic level;
        logic enable;
    } pin_t;

endpackage

// [capture_compare_timer16_ctrl.sv]
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module capture_compare_timer16_ctrl
    import timer16_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter bit HAS_EXT_CLK = 1'b1
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic HALT_MODE,
    input wire logic CPU_IRQ_MASK,
    input wire logic CAPTURE_IN_ONE,
    input wire logic CAPTURE_IN_TWO,
    input wire logic EXT_COUNT_PIN,
    output logic COMPARE_OUT_ONE,
    output logic COMPARE_OUT_ONE_EN,
    output logic COMPARE_OUT_TWO,
    output logic COMPARE_OUT_TWO_EN,
    output logic TIMER_IRQ
);

    // The decode compares eight address bits, so a narrower bus cannot work.
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    // True when the bus address selects the given register, whether or not the access is taken.
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] target);
        hits = (addr == ADDR_W'(target));
    endfunction

    // True when the prescaler phase has reached the end of its divide.
    function automatic logic phase_done(input logic [2:0] phase, input logic [2:0] mask);
        phase_done = ((phase & mask) == mask);
    endfunction

    ctrl_one_t ctrl_one; // Interrupt enables, force, level and edge bits.
    ctrl_two_t ctrl_two; // Pin enables, modes, clock and edge select.
    flags_t flags; // Sticky hardware event flags.
    flags_t armed; // Flags seen set by a status read, awaiting step two.
    logic timer_freeze; // Software freeze of prescaler, counter and pins.
    logic [15:0] counter; // The free running counter.
    logic [2:0] prescale; // Prescaler phase.
    logic [15:0] cmp_one; // Compare value one.
    logic [15:0] cmp_two; // Compare value two.
    logic cmp_one_live; // Low after a high byte write, until low byte write.
    logic cmp_two_live; // Same inhibit for compare two.
    logic [15:0] cap_one; // Capture value one.
    logic [15:0] cap_two; // Capture value two.
    logic moved; // Counter stepped on the previous edge.
    logic in_one_q; // Previous sample of capture input one.
    logic in_two_q; // Previous sample of capture input two.
    logic ext_q; // Previous sample of the external count pin.
    logic halt_q; // Previous halt level, for the exit edge.
    logic halt_arm_one; // Capture one edge seen while halted.
    logic halt_arm_two; // Capture two edge seen while halted.
    pin_t pin_one; // Internal state of compare output one.
    pin_t pin_two; // Internal state of compare output two.
    logic wait_q; // Registered waitrequest.
    logic [7:0] next_readdata; // Read data chosen for the current address.

    // Bus handshake: a request is answered one cycle after it is seen.
    wire logic req = AVS_READ || AVS_WRITE;
    wire logic taken = req && !wait_q;
    wire logic rd = taken && AVS_READ;
    wire logic wr = taken && AVS_WRITE && AVS_BYTEENABLE[0];
    wire logic [7:0] wdata = AVS_WRITEDATA[7:0];
    wire logic acc = taken;

    // Mode decode; PWM takes precedence when both mode bits are set.
    wire logic pwm_on = ctrl_two.pwm_sel;
    wire logic pulse_on = ctrl_two.single_pulse_sel && !ctrl_two.pwm_sel;

    // Edge detection on the pins, each with its own polarity select.
    wire logic edge_one = ctrl_one.capture_edge_one ? (CAPTURE_IN_ONE && !in_one_q)
                                                    : (!CAPTURE_IN_ONE && in_one_q);
    wire logic edge_two = ctrl_two.capture_edge_two ? (CAPTURE_IN_TWO && !in_two_q)
                                                    : (!CAPTURE_IN_TWO && in_two_q);
    wire logic ext_edge = ctrl_two.ext_count_edge ? (EXT_COUNT_PIN && !ext_q)
                                                  : (!EXT_COUNT_PIN && ext_q);

    // Halt exit is the falling edge of the halt level; wake by reset is ARST_N.
    wire logic halt_exit = halt_q && !HALT_MODE;
    wire logic running = !HALT_MODE && !timer_freeze;

    // A counter write through either low byte restarts the count.
    wire logic cnt_restart = wr && (hits(AVS_ADDRESS, ADDR_CNT_LO) || hits(AVS_ADDRESS, ADDR_ALT_LO));

    // Counting tick from the prescaler or the external pin.
    logic tick;
    always_comb begin
        tick = 1'b0;
        case (ctrl_two.clock_source_sel)
            CLK_DIV4: tick = phase_done(prescale, MASK_DIV4);
            CLK_DIV2: tick = phase_done(prescale, MASK_DIV2);
            CLK_DIV8: tick = phase_done(prescale, MASK_DIV8);
            CLK_EXT: tick = HAS_EXT_CLK && ext_edge;
            default: tick = 1'b0;
        endcase
        tick = tick && running;
    end

    // Match events fire once, when the counter steps onto the compare value.
    wire logic match_one = moved && cmp_one_live && (counter == cmp_one);
    wire logic match_two = moved && cmp_two_live && (counter == cmp_two);

    // Single pulse trigger comes from capture one in pulse mode.
    wire logic pulse_trig = pulse_on && edge_one && running;
    wire logic pwm_reload = pwm_on && match_two;

    // Ordinary captures; capture one pin belongs to the modes when they are on.
    wire logic cap_one_now = edge_one && !pwm_on && !pulse_on && !HALT_MODE;
    wire logic cap_two_now = edge_two && !HALT_MODE;
    wire logic cap_one_wake = halt_exit && halt_arm_one;
    wire logic cap_two_wake = halt_exit && halt_arm_two;

    // Clear strobes: step two of the clear sequence on each flag's own low byte; ADDR_ALT_LO clears nothing.
    wire logic clr_cap_one = acc && armed.capture_flag_one && hits(AVS_ADDRESS, ADDR_CAP1_LO);
    wire logic clr_cap_two = acc && armed.capture_flag_two && hits(AVS_ADDRESS, ADDR_CAP2_LO);
    wire logic clr_match_one = acc && armed.match_flag_one && hits(AVS_ADDRESS, ADDR_CMP1_LO);
    wire logic clr_match_two = acc && armed.match_flag_two && hits(AVS_ADDRESS, ADDR_CMP2_LO);
    wire logic clr_wrap = acc && armed.wrap_flag && hits(AVS_ADDRESS, ADDR_CNT_LO);

    // Flag set terms.
    wire logic set_cap_one = cap_one_now || cap_one_wake || pwm_reload || pulse_trig;
    wire logic set_cap_two = cap_two_now || cap_two_wake;
    wire logic set_match_one = match_one && !pwm_on && !pulse_on;
    wire logic set_match_two = match_two && !pwm_on;
    wire logic set_wrap = tick && (counter == COUNTER_TOP);

    // Waitrequest idles high and drops for the one cycle in which a request is taken.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end
    assign AVS_WAITREQUEST = wait_q;

    // Read mux; unmapped addresses and reserved status bits read as zero.
    always_comb begin
        next_readdata = 8'h00;
        if (hits(AVS_ADDRESS, ADDR_CTRL_ONE)) begin
            next_readdata = ctrl_one;
        end else if (hits(AVS_ADDRESS, ADDR_CTRL_TWO)) begin
            next_readdata = ctrl_two;
        end else if (hits(AVS_ADDRESS, ADDR_STATUS)) begin
            next_readdata = {flags, timer_freeze, 2'b00};
        end else if (hits(AVS_ADDRESS, ADDR_CAP1_HI)) begin
            next_readdata = cap_one[15:8];
        end else if (hits(AVS_ADDRESS, ADDR_CAP1_LO)) begin
            next_readdata = cap_one[7:0];
        end else if (hits(AVS_ADDRESS, ADDR_CMP1_HI)) begin
            next_readdata = cmp_one[15:8];
        end else if (hits(AVS_ADDRESS, ADDR_CMP1_LO)) begin
            next_readdata = cmp_one[7:0];
        end else if (hits(AVS_ADDRESS, ADDR_CMP2_HI)) begin
            next_readdata = cmp_two[15:8];
        end else if (hits(AVS_ADDRESS, ADDR_CMP2_LO)) begin
            next_readdata = cmp_two[7:0];
        end else if (hits(AVS_ADDRESS, ADDR_CNT_HI) || hits(AVS_ADDRESS, ADDR_ALT_HI)) begin
            next_readdata = counter[15:8];
        end else if (hits(AVS_ADDRESS, ADDR_CNT_LO) || hits(AVS_ADDRESS, ADDR_ALT_LO)) begin
            next_readdata = counter[7:0];
        end else if (hits(AVS_ADDRESS, ADDR_CAP2_HI)) begin
            next_readdata = cap_two[15:8];
        end else if (hits(AVS_ADDRESS, ADDR_CAP2_LO)) begin
            next_readdata = cap_two[7:0];
        end
    end

    // Read data is loaded as the request is first seen, so it stands when waitrequest drops.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (req && wait_q) begin
            AVS_READDATA <= {24'h00_0000, next_readdata};
        end
    end

    // Control registers and the software freeze bit.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_one <= CTRL_RESET;
            ctrl_two <= CTRL_RESET;
            timer_freeze <= 1'b0;
        end else if (wr) begin
            if (hits(AVS_ADDRESS, ADDR_CTRL_ONE)) begin
                ctrl_one <= wdata;
            end
            if (hits(AVS_ADDRESS, ADDR_CTRL_TWO)) begin
                ctrl_two <= wdata;
            end
            if (hits(AVS_ADDRESS, ADDR_STATUS)) begin
                timer_freeze <= wdata[2];
            end
        end
    end

    // Compare values; a high byte write holds matching off until the low byte follows.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_one <= COMPARE_RESET;
            cmp_two <= COMPARE_RESET;
            cmp_one_live <= 1'b1;
            cmp_two_live <= 1'b1;
        end else if (wr) begin
            if (hits(AVS_ADDRESS, ADDR_CMP1_HI)) begin
                cmp_one[15:8] <= wdata;
                cmp_one_live <= 1'b0;
            end
            if (hits(AVS_ADDRESS, ADDR_CMP1_LO)) begin
                cmp_one[7:0] <= wdata;
                cmp_one_live <= 1'b1;
            end
            if (hits(AVS_ADDRESS, ADDR_CMP2_HI)) begin
                cmp_two[15:8] <= wdata;
                cmp_two_live <= 1'b0;
            end
            if (hits(AVS_ADDRESS, ADDR_CMP2_LO)) begin
                cmp_two[7:0] <= wdata;
                cmp_two_live <= 1'b1;
            end
        end
    end

    // Pin samples and the halt level, kept for edge detection.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_one_q <= 1'b0;
            in_two_q <= 1'b0;
            ext_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            in_one_q <= CAPTURE_IN_ONE;
            in_two_q <= CAPTURE_IN_TWO;
            ext_q <= EXT_COUNT_PIN;
            halt_q <= HALT_MODE;
        end
    end

    // Prescaler; it stops with the counter so the phase survives halt and freeze.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prescale <= 3'h0;
        end else if (cnt_restart) begin
            prescale <= 3'h0;
        end else if (running) begin
            prescale <= prescale + 3'h1;
        end
    end

    // Counter: software restart, then mode reloads, then the counting tick.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            counter <= COUNTER_RESET;
            moved <= 1'b0;
        end else begin
            moved <= 1'b0;
            if (cnt_restart) begin
                counter <= COUNTER_RESET;
            end else if (running && (pwm_reload || pulse_trig)) begin
                counter <= COUNTER_RESET;
            end else if (tick) begin
                counter <= counter + 16'h0001;
                moved <= 1'b1;
            end
        end
    end

    // Halt capture arming; edges during halt are held until the wake.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            halt_arm_one <= 1'b0;
            halt_arm_two <= 1'b0;
        end else if (halt_exit) begin
            halt_arm_one <= 1'b0;
            halt_arm_two <= 1'b0;
        end else if (HALT_MODE) begin
            if (edge_one && !pwm_on && !pulse_on) begin
                halt_arm_one <= 1'b1;
            end
            if (edge_two) begin
                halt_arm_two <= 1'b1;
            end
        end
    end

    // Capture registers; the wake capture takes the count present at halt exit.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cap_one <= CAPTURE_RESET;
            cap_two <= CAPTURE_RESET;
        end else begin
            if (pulse_trig) begin
                cap_one <= PULSE_CAPTURE;
            end else if (cap_one_now || cap_one_wake) begin
                cap_one <= counter;
            end
            if (cap_two_now || cap_two_wake) begin
                cap_two <= counter;
            end
        end
    end

    // Status read arms each flag it returned set, so an unseen later event is never cleared.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            armed <= '0;
        end else if (rd && hits(AVS_ADDRESS, ADDR_STATUS)) begin
            armed <= flags & AVS_READDATA[7:3];
        end else begin
            if (clr_cap_one) armed.capture_flag_one <= 1'b0;
            if (clr_cap_two) armed.capture_flag_two <= 1'b0;
            if (clr_match_one) armed.match_flag_one <= 1'b0;
            if (clr_match_two) armed.match_flag_two <= 1'b0;
            if (clr_wrap) armed.wrap_flag <= 1'b0;
        end
    end

    // Sticky flags; a set in the clearing cycle wins so no event is lost.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flags <= '0;
        end else begin
            if (set_cap_one) flags.capture_flag_one <= 1'b1;
            else if (clr_cap_one) flags.capture_flag_one <= 1'b0;
            if (set_cap_two) flags.capture_flag_two <= 1'b1;
            else if (clr_cap_two) flags.capture_flag_two <= 1'b0;
            if (set_match_one) flags.match_flag_one <= 1'b1;
            else if (clr_match_one) flags.match_flag_one <= 1'b0;
            if (set_match_two) flags.match_flag_two <= 1'b1;
            else if (clr_match_two) flags.match_flag_two <= 1'b0;
            if (set_wrap) flags.wrap_flag <= 1'b1;
            else if (clr_wrap) flags.wrap_flag <= 1'b0;
        end
    end

    // Compare output one level; updated only while its pin is connected and not frozen.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_one.level <= 1'b0;
        end else if (ctrl_two.compare_pin_one_en && !timer_freeze) begin
            if (pwm_on) begin
                if (match_two) begin
                    pin_one.level <= ctrl_one.level_bit_two;
                end else if (match_one) begin
                    pin_one.level <= ctrl_one.level_bit_one;
                end
            end else if (pulse_on) begin
                if (pulse_trig) begin
                    pin_one.level <= ctrl_one.level_bit_two;
                end else if (match_one) begin
                    pin_one.level <= ctrl_one.level_bit_one;
                end
            end else if (wr && hits(AVS_ADDRESS, ADDR_CTRL_ONE) && wdata[3]) begin
                pin_one.level <= wdata[0];
            end else if (match_one) begin
                pin_one.level <= ctrl_one.level_bit_one;
            end
        end
    end

    // Compare output two level; level two belongs to pin one in the two modes.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_two.level <= 1'b0;
        end else if (ctrl_two.compare_pin_two_en && !timer_freeze && !pwm_on && !pulse_on) begin
            if (wr && hits(AVS_ADDRESS, ADDR_CTRL_ONE) && wdata[4]) begin
                pin_two.level <= wdata[2];
            end else if (match_two) begin
                pin_two.level <= ctrl_one.level_bit_two;
            end
        end
    end

    // Pin connection; a released pin goes back to general I/O, matching carries on.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_one.enable <= 1'b0;
            pin_two.enable <= 1'b0;
        end else begin
            pin_one.enable <= ctrl_two.compare_pin_one_en && !timer_freeze;
            pin_two.enable <= ctrl_two.compare_pin_two_en && !timer_freeze;
        end
    end
    assign COMPARE_OUT_ONE = pin_one.level;
    assign COMPARE_OUT_ONE_EN = pin_one.enable;
    assign COMPARE_OUT_TWO = pin_two.level;
    assign COMPARE_OUT_TWO_EN = pin_two.enable;

    // One shared request; it stays live in wait mode so it can wake the core.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TIMER_IRQ <= 1'b0;
        end else begin
            TIMER_IRQ <= !CPU_IRQ_MASK &&
                ((ctrl_one.capture_irq_enable &&
                  (flags.capture_flag_one || flags.capture_flag_two)) ||
                 (ctrl_one.compare_irq_enable &&
                  (flags.match_flag_one || flags.match_flag_two)) ||
                 (ctrl_one.overflow_irq_enable && flags.wrap_flag));
        end
    end

endmodule

// [timer16_properties.sv]
`timescale 1ns/1ps
module timer16_checker
    import timer16_pkg::*;
#(parameter int ADDR_W = 8) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CPU_IRQ_MASK,
    input wire logic COMPARE_OUT_ONE,
    input wire logic COMPARE_OUT_ONE_EN,
    input wire logic COMPARE_OUT_TWO,
    input wire logic TIMER_IRQ
);
    logic [7:0] c1;
    logic [7:0] c2;
    logic frz;
    wire logic take = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    // Shadow control bits from taken writes, since the checker cannot see the registers.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            c1 <= 8'h00;
            c2 <= 8'h00;
            frz <= 1'b0;
        end else if (take) begin
            if (AVS_ADDRESS == ADDR_W'(ADDR_CTRL_ONE)) c1 <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == ADDR_W'(ADDR_CTRL_TWO)) c2 <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == ADDR_W'(ADDR_STATUS)) frz <= AVS_WRITEDATA[2];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_irq_masked: assert property ($past(CPU_IRQ_MASK) |-> !TIMER_IRQ)
        else $error("irq raised while masked");
    a_irq_gated: assert property ($past(c1[7:5]) == 3'b000 |-> !TIMER_IRQ)
        else $error("irq raised with all enables clear");
    a_pin_enable: assert property (COMPARE_OUT_ONE_EN == $past(c2[7] && !frz))
        else $error("pin one enable wrong");
    a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered");
    a_frozen_pins: assert property ($past(frz) |-> $stable(COMPARE_OUT_ONE) && $stable(COMPARE_OUT_TWO))
        else $error("pin moved while frozen");
    a_freeze_read: assert property ($past(AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == ADDR_W'(ADDR_STATUS))
        |-> AVS_READDATA[31:0] == {AVS_READDATA[31:8] & 24'h0, AVS_READDATA[7:3], frz, 2'b00})
        else $error("status readback wrong");
    a_force_one: assert property (take && AVS_ADDRESS == ADDR_W'(ADDR_CTRL_ONE) && AVS_WRITEDATA[3]
        && c2[7] && c2[5:4] == 2'b00 && !frz |-> ##[1:3] COMPARE_OUT_ONE == c1[0])
        else $error("forced level not on pin one");
endmodule
bind capture_compare_timer16_ctrl timer16_checker #(.ADDR_W(ADDR_W)) chk_i (.CLK, .ARST_N,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
    .AVS_WAITREQUEST, .CPU_IRQ_MASK, .COMPARE_OUT_ONE, .COMPARE_OUT_ONE_EN, .COMPARE_OUT_TWO,
    .TIMER_IRQ);

// [timer16_pins_model.sv]
`timescale 1ns/1ps
module timer16_pins_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] cap_req,
    input wire logic run_ext,
    output logic cap_one,
    output logic cap_two,
    output logic ext_pin
);
    // Pins change just after the edge, as a synchronous outside source would.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_one <= 1'b0;
            cap_two <= 1'b0;
            ext_pin <= 1'b0;
        end else begin
            cap_one <= cap_req[0];
            cap_two <= cap_req[1];
            ext_pin <= run_ext ? !ext_pin : ext_pin;
        end
    end
endmodule

// [capture_compare_timer16_ctrl_tb.sv]
`timescale 1ns/1ps
module capture_compare_timer16_ctrl_tb;
    import timer16_pkg::*;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic CPU_IRQ_MASK = 1'b1;
    logic HALT_MODE = 1'b0;
    logic [1:0] cap_req = 2'b00;
    logic cap_one, cap_two, ext_pin, out1, en1, out2, en2, irq;
    logic [7:0] q;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #25 CLK = !CLK;
    capture_compare_timer16_ctrl uut (.CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE(4'h1), .AVS_READDATA, .AVS_WAITREQUEST, .HALT_MODE,
        .CPU_IRQ_MASK, .CAPTURE_IN_ONE(cap_one), .CAPTURE_IN_TWO(cap_two), .EXT_COUNT_PIN(ext_pin),
        .COMPARE_OUT_ONE(out1), .COMPARE_OUT_ONE_EN(en1), .COMPARE_OUT_TWO(out2),
        .COMPARE_OUT_TWO_EN(en2), .TIMER_IRQ(irq));
    timer16_pins_model pins (.clk(CLK), .rst_n(ARST_N), .cap_req, .run_ext(1'b0), .cap_one,
        .cap_two, .ext_pin);
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One bus access; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA[7:0];
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask
    function automatic logic [7:0] pin_en(input logic [7:0] c2, input logic frz);
        return {7'h0, c2[7] & !frz};
    endfunction
    // A hang ends the run through the same closing report.
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        logic [7:0] v;
        void'($urandom(13977));
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        rdchk(ADDR_CMP1_HI, 8'hff, 8'h80);
        rdchk(ADDR_CTRL_TWO, 8'hff, 8'h00);
        rdchk(8'h3c, 8'hff, 8'h00);
        repeat (4) begin
            v = 8'($urandom);
            bus(1'b1, ADDR_CTRL_TWO, v);
            rdchk(ADDR_CTRL_TWO, 8'hff, v);
            bus(1'b1, ADDR_CTRL_ONE, ~v);
            rdchk(ADDR_CTRL_ONE, 8'hff, ~v);
        end
        $display("registers test done");
        bus(1'b1, ADDR_CMP1_HI, 8'h00);
        bus(1'b1, ADDR_CMP1_LO, 8'h05);
        bus(1'b1, ADDR_CTRL_ONE, 8'h21);
        bus(1'b1, ADDR_CTRL_TWO, 8'hc6);
        CPU_IRQ_MASK <= 1'b0;
        bus(1'b1, ADDR_CNT_LO, 8'h00);
        cap_req <= 2'b10;
        repeat (40) @(posedge CLK);
        chk({7'h0, out1}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rdchk(ADDR_STATUS, 8'h70, 8'h70);
        bus(1'b0, ADDR_ALT_LO, 8'h00);
        rdchk(ADDR_STATUS, 8'h20, 8'h20);
        bus(1'b0, ADDR_CNT_LO, 8'h00);
        bus(1'b0, ADDR_STATUS, 8'h00);
        bus(1'b0, ADDR_CMP1_LO, 8'h00);
        rdchk(ADDR_STATUS, 8'h60, 8'h00);
        CPU_IRQ_MASK <= 1'b1;
        bus(1'b1, ADDR_CTRL_ONE, 8'h1c);
        repeat (3) @(posedge CLK);
        chk({7'h0, out1}, 8'h00);
        chk({7'h0, out2}, 8'h01);
        $display("flags test done");
        bus(1'b1, ADDR_STATUS, 8'h04);
        repeat (2) @(posedge CLK);
        chk({7'h0, en1}, pin_en(8'hc6, 1'b1));
        chk({7'h0, en2}, 8'h00);
        bus(1'b0, ADDR_CNT_LO, 8'h00);
        v = q;
        repeat (10) @(posedge CLK);
        rdchk(ADDR_CNT_LO, 8'hff, v);
        bus(1'b1, ADDR_STATUS, 8'h00);
        repeat (2) @(posedge CLK);
        chk({7'h0, en1}, pin_en(8'hc6, 1'b0));
        chk({7'h0, en2}, 8'h01);
        $display("freeze test done");
        HALT_MODE <= 1'b1;
        cap_req <= 2'b00;
        bus(1'b0, ADDR_CNT_LO, 8'h00);
        v = q;
        cap_req <= 2'b10;
        repeat (10) @(posedge CLK);
        rdchk(ADDR_CNT_LO, 8'hff, v);
        HALT_MODE <= 1'b0;
        repeat (2) @(posedge CLK);
        rdchk(ADDR_CAP2_LO, 8'hff, v);
        $display("halt test done");
        finish_test();
    end
endmodule
